// [hw/dsag_defines.vh]
/*
  constants for the dual space address generator: register map, field
  positions, reset values, operand mode codes and pointer numbers.
  assumes a 16-bit working register file of sixteen entries.
*/
`ifndef DSAG_DEFINES_VH
`define DSAG_DEFINES_VH

// byte addresses on the register bus
`define OFS_MOD_CTRL     8'h00
`define OFS_X_MOD_START  8'h04
`define OFS_X_MOD_END    8'h08
`define OFS_Y_MOD_START  8'h0C
`define OFS_Y_MOD_END    8'h10
`define OFS_STATUS       8'h14
`define OFS_BITREV_CTRL  8'h50

// modulo control fields
`define MC_X_EN          0
`define MC_Y_EN          1
`define MC_X_SEL_LO      4
`define MC_Y_SEL_LO      8
`define MC_X_DEC         12
`define MC_Y_DEC         13
`define MC_X_BIDIR       14
`define MC_Y_BIDIR       15
`define MC_RESET         16'h0000

// status fields, write one to clear
`define ST_ILLEGAL       0
`define ST_X_WRAP        1
`define ST_Y_WRAP        2

// bit reversal control fields
`define BR_ENABLE        15
`define BITREV_RESET     16'h0000

// buffer bounds: start is even, end is odd
`define START_RESET      16'h0000
`define END_RESET        16'h0001

// operand modes
`define M_DIRECT         4'h0
`define M_IND            4'h1
`define M_POSTINC        4'h2
`define M_POSTDEC        4'h3
`define M_PREINC         4'h4
`define M_PREDEC         4'h5
`define M_INDEX          4'h6
`define M_LITOFS         4'h7
`define M_LIT8           4'h8
`define M_LIT16          4'h9
`define M_MAC_P2         4'hA
`define M_MAC_P4         4'hB
`define M_MAC_P6         4'hC
`define M_MAC_N2         4'hD
`define M_MAC_N4         4'hE
`define M_MAC_N6         4'hF

// operand kinds on the result ports
`define KIND_MEM         2'h0
`define KIND_REG         2'h1
`define KIND_LIT         2'h2

// prefetch pointer numbers
`define REG_XP1          4'h8
`define REG_XP2          4'h9
`define REG_YP1          4'hA
`define REG_YP2          4'hB

`endif

// [hw/modulo_wrap.v]
/*
  modulo_wrap: folds a modified pointer back into a circular buffer.
  assumes start is even, end is odd and software keeps the direction rules.
*/
`default_nettype none

module modulo_wrap (
  input  wire [15:0] raw_i,
  input  wire        neg_i,
  input  wire        en_i,
  input  wire        dec_dir_i,
  input  wire        bidir_i,
  input  wire [15:0] start_i,
  input  wire [15:0] end_i,
  output wire [15:0] next_o,
  output wire        wrap_o
);
  wire [15:0] len;
  wire        pow2;
  wire        chk_up;
  wire        chk_dn;
  wire        over;
  wire        under;

  // bidirectional only honoured for power-of-two lengths
  assign len    = end_i - start_i + 16'h0001;
  assign pow2   = (len != 16'h0000) && ((len & (len - 16'h0001)) == 16'h0000);
  assign chk_up = (bidir_i & pow2) | ~dec_dir_i;   // R12
  assign chk_dn = (bidir_i & pow2) | dec_dir_i;    // R12

  // past end restarts at start, below start restarts at end
  assign over   = en_i & ~neg_i & chk_up & (raw_i > end_i);     // R13
  assign under  = en_i & neg_i & chk_dn & (raw_i < start_i);    // R13
  assign next_o = over  ? raw_i - end_i - 16'h0001 + start_i :
                  under ? raw_i + end_i + 16'h0001 - start_i : raw_i;  // R8
  assign wrap_o = over | under;
endmodule // modulo_wrap

`default_nettype wire

// [hw/dual_space_agu.v]
/*
  dual_space_agu: operand address generation for move, accumulator and
  dual-operand multiply-accumulate instructions, with one circular buffer in
  x space and one in y space, plus bit-reversed post-increment on x.
  assumes the decoder presents pointer contents and the offset register value
  from the register file, and writes back updated pointers it is given.
*/
`default_nettype none
`include "dsag_defines.vh"

// Overview of operation
// R1: mac prefetch pointers must be x_pointer_first/second or y_pointer_first/second only.
// R2: x pointers always use the x generator, y pointers the y generator; here only mac channel b uses y, move operands all go through x.
// R3: software keeps x pointers in x space and y pointers in y space.
// R4: mac indexed mode only on x_pointer_second and y_pointer_second.
// R5: mac modes: indirect, indexed, post-modify by 2, 4 or 6.
// R6: move source and destination modes independent; one offset field shared.
// R7: move modes: direct, indirect, pre/post modify, indexed, literal offset, literals.
// R8: circular buffer wrap done in hardware with no software help.
// R9: one buffer in x space, one in y space; x buffer covers program space.
// R10: modulo allowed on any pointer; frame and stack pointers not advised.
// R11: software configures each buffer for one direction with matching alignment.
// R12: power-of-two buffers may run bidirectionally, checking both bounds.
// R13: past end wraps to start; below start wraps to end.
module dual_space_agu (
  input  wire        core_clk_i,
  input  wire        rst_i,
  // avalon-mm register slave
  input  wire [7:0]  avs_address_i,
  input  wire        avs_read_i,
  input  wire        avs_write_i,
  input  wire [31:0] avs_writedata_i,
  input  wire [3:0]  avs_byteenable_i,
  output reg  [31:0] avs_readdata_o,
  output wire        avs_waitrequest_o,
  // decoder request: channel a is x / source, channel b is y / destination
  input  wire        req_valid_i,
  input  wire        mac_i,
  input  wire        byte_i,
  input  wire [3:0]  offset_register_field_i,
  input  wire [15:0] ofs_data_i,
  input  wire [15:0] lit_i,
  input  wire        a_en_i,
  input  wire [3:0]  a_mode_i,
  input  wire [3:0]  a_reg_i,
  input  wire [15:0] a_ptr_i,
  input  wire        b_en_i,
  input  wire [3:0]  b_mode_i,
  input  wire [3:0]  b_reg_i,
  input  wire [15:0] b_ptr_i,
  output wire [3:0]  ofs_sel_o,
  // results towards the data memories and register file
  output reg         valid_o,
  output reg         illegal_o,
  output reg  [15:0] a_addr_o,
  output reg  [1:0]  a_kind_o,
  output reg         a_space_o,
  output reg         a_wb_o,
  output reg  [15:0] a_wb_data_o,
  output reg  [15:0] b_addr_o,
  output reg  [1:0]  b_kind_o,
  output reg         b_space_o,
  output reg         b_wb_o,
  output reg  [15:0] b_wb_data_o
);

  reg  [15:0] mod_ctrl;
  reg  [15:0] x_start;
  reg  [15:0] x_end;
  reg  [15:0] y_start;
  reg  [15:0] y_end;
  reg  [15:0] bitrev_ctrl;
  reg  [2:0]  status;
  reg         ack;
  reg  [15:0] rd_mux;
  reg  [15:0] wr_val;

  wire        bus_req;
  wire        wr_go;
  wire [3:0]  x_sel;
  wire [3:0]  y_sel;
  wire        bitrev_enable;
  wire [14:0] bitrev_modifier;
  wire        any_bad;
  wire        x_wrap_evt;
  wire        y_wrap_evt;
  wire        st_wr;

  wire        en_w   [0:1];
  wire [3:0]  mode_w [0:1];
  wire [3:0]  reg_w  [0:1];
  wire [15:0] ptr_w  [0:1];
  wire [15:0] ea_w   [0:1];
  wire [1:0]  kind_w [0:1];
  wire        spc_w  [0:1];
  wire        wb_w   [0:1];
  wire [15:0] nxt_w  [0:1];
  wire        bad_w  [0:1];
  wire        wrap_w [0:1];

  assign en_w[0]   = a_en_i;
  assign en_w[1]   = b_en_i;
  assign mode_w[0] = a_mode_i;
  assign mode_w[1] = b_mode_i;
  assign reg_w[0]  = a_reg_i;
  assign reg_w[1]  = b_reg_i;
  assign ptr_w[0]  = a_ptr_i;
  assign ptr_w[1]  = b_ptr_i;

  assign x_sel           = mod_ctrl[`MC_X_SEL_LO+3:`MC_X_SEL_LO];
  assign y_sel           = mod_ctrl[`MC_Y_SEL_LO+3:`MC_Y_SEL_LO];
  assign bitrev_enable   = bitrev_ctrl[`BR_ENABLE];
  assign bitrev_modifier = bitrev_ctrl[14:0];

  // one offset register feeds both source and destination calculations
  assign ofs_sel_o = offset_register_field_i;  // R6

  // reversed-carry add: the carry ripples from msb towards lsb
  function [15:0] rev_add;
    input [15:0] p;
    input [15:0] m;
    reg   [15:0] rp;
    reg   [15:0] rm;
    reg   [15:0] s;
    integer      i;
    begin
      for (i = 0; i < 16; i = i + 1) begin
        rp[i] = p[15-i];
        rm[i] = m[15-i];
      end
      s = rp + rm;
      for (i = 0; i < 16; i = i + 1) begin
        rev_add[i] = s[15-i];
      end
    end
  endfunction

  // byte-lane merge for a 16-bit register in the low half of the word
  function [15:0] merge16;
    input [15:0] old;
    input [31:0] wd;
    input [3:0]  be;
    begin
      merge16[7:0]  = be[0] ? wd[7:0]  : old[7:0];
      merge16[15:8] = be[1] ? wd[15:8] : old[15:8];
    end
  endfunction

  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1) begin : chan
      reg  [15:0] step;
      reg         neg;
      reg         pre;
      reg         upd;
      reg         mode_ok;
      reg  [15:0] ea;
      reg  [1:0]  kind;
      wire        use_y;
      wire [3:0]  sel;
      wire        mod_hit;
      wire        br_hit;
      wire [15:0] raw;
      wire [15:0] wrapped;
      wire        wrapped_f;
      wire        ptr_ok;
      wire        idx_ok;

      // mac channel b is the y generator; all else goes through x
      assign use_y   = mac_i && (g == 1);  // R2
      assign sel     = use_y ? y_sel : x_sel;  // R9
      // any pointer number may be the modulo pointer, stack ones included
      assign mod_hit = (use_y ? mod_ctrl[`MC_Y_EN] : mod_ctrl[`MC_X_EN]) & (sel == reg_w[g]);  // R10
      // bit reversal only on x post-increment and takes priority over modulo
      assign br_hit  = bitrev_enable & ~use_y & (x_sel == reg_w[g]) & (mode_w[g] == `M_POSTINC);

      // step size and direction per mode
      always @* begin
        step    = byte_i ? 16'h0001 : 16'h0002;
        neg     = 1'b0;
        pre     = 1'b0;
        upd     = 1'b0;
        mode_ok = ~mac_i;
        case (mode_w[g])
          `M_IND:     mode_ok = 1'b1;  // R5
          `M_INDEX:   mode_ok = 1'b1;  // R5
          `M_POSTINC: upd = 1'b1;
          `M_POSTDEC: begin
            upd = 1'b1;
            neg = 1'b1;
          end
          `M_PREINC: begin
            upd = 1'b1;
            pre = 1'b1;
          end
          `M_PREDEC: begin
            upd = 1'b1;
            pre = 1'b1;
            neg = 1'b1;
          end
          `M_MAC_P2, `M_MAC_P4, `M_MAC_P6, `M_MAC_N2, `M_MAC_N4, `M_MAC_N6: begin
            mode_ok = mac_i;  // R5
            upd     = 1'b1;
            neg     = mode_w[g] > `M_MAC_P6;
            case (mode_w[g])
              `M_MAC_P2, `M_MAC_N2: step = 16'h0002;
              `M_MAC_P4, `M_MAC_N4: step = 16'h0004;
              default:              step = 16'h0006;
            endcase
          end
          default: ;
        endcase
      end

      assign raw = neg ? ptr_w[g] - step : ptr_w[g] + step;

      modulo_wrap u_wrap (
        .raw_i     (raw),
        .neg_i     (neg),
        .en_i      (mod_hit & ~br_hit),
        .dec_dir_i (use_y ? mod_ctrl[`MC_Y_DEC] : mod_ctrl[`MC_X_DEC]),
        .bidir_i   (use_y ? mod_ctrl[`MC_Y_BIDIR] : mod_ctrl[`MC_X_BIDIR]),
        .start_i   (use_y ? y_start : x_start),
        .end_i     (use_y ? y_end : x_end),
        .next_o    (wrapped),
        .wrap_o    (wrapped_f)
      );

      // updated pointer: reversed carry, else modulo fold
      assign nxt_w[g] = br_hit ? rev_add(ptr_w[g], {1'b0, bitrev_modifier}) : wrapped;  // R8

      // effective address per mode; post-modify uses the old pointer
      always @* begin
        ea   = ptr_w[g];
        kind = `KIND_MEM;
        case (mode_w[g])
          `M_DIRECT: kind = `KIND_REG;  // R7
          `M_INDEX:  ea = ptr_w[g] + ofs_data_i;  // R6
          `M_LITOFS: ea = ptr_w[g] + lit_i;  // R7
          `M_LIT8: begin
            ea   = {8'h00, lit_i[7:0]};  // R7
            kind = `KIND_LIT;
          end
          `M_LIT16: begin
            ea   = lit_i;  // R7
            kind = `KIND_LIT;
          end
          default: ea = pre ? nxt_w[g] : ptr_w[g];  // R7
        endcase
      end

      // mac operands: a takes only x pointers, b only y pointers
      assign ptr_ok = (g == 0) ? (reg_w[g] == `REG_XP1) | (reg_w[g] == `REG_XP2) :
                                 (reg_w[g] == `REG_YP1) | (reg_w[g] == `REG_YP2);  // R1
      assign idx_ok = (mode_w[g] != `M_INDEX) | (reg_w[g] == ((g == 0) ? `REG_XP2 : `REG_YP2));  // R4

      assign bad_w[g]  = en_w[g] & (~mode_ok | (mac_i & (~ptr_ok | ~idx_ok)));  // R1
      assign ea_w[g]   = ea;
      assign kind_w[g] = kind;
      assign spc_w[g]  = use_y;  // R2
      assign wb_w[g]   = en_w[g] & upd;
      assign wrap_w[g] = en_w[g] & upd & wrapped_f & ~br_hit;
    end
  endgenerate

  assign any_bad    = bad_w[0] | bad_w[1];
  assign x_wrap_evt = req_valid_i & ~any_bad & (wrap_w[0] | (~mac_i & wrap_w[1]));
  assign y_wrap_evt = req_valid_i & ~any_bad & mac_i & wrap_w[1];

  // result stage: a faulty request updates no pointer at all
  always @(posedge core_clk_i) begin
    if (rst_i) begin
      valid_o     <= 1'b0;
      illegal_o   <= 1'b0;
      a_addr_o    <= 16'h0000;
      a_kind_o    <= `KIND_MEM;
      a_space_o   <= 1'b0;
      a_wb_o      <= 1'b0;
      a_wb_data_o <= 16'h0000;
      b_addr_o    <= 16'h0000;
      b_kind_o    <= `KIND_MEM;
      b_space_o   <= 1'b0;
      b_wb_o      <= 1'b0;
      b_wb_data_o <= 16'h0000;
    end else begin
      valid_o   <= req_valid_i;
      illegal_o <= req_valid_i & any_bad;  // R1
      a_wb_o    <= req_valid_i & ~any_bad & wb_w[0];
      b_wb_o    <= req_valid_i & ~any_bad & wb_w[1];
      if (req_valid_i) begin
        a_addr_o    <= ea_w[0];
        a_kind_o    <= kind_w[0];
        a_space_o   <= spc_w[0];
        a_wb_data_o <= nxt_w[0];
        b_addr_o    <= ea_w[1];
        b_kind_o    <= kind_w[1];
        b_space_o   <= spc_w[1];  // R2
        b_wb_data_o <= nxt_w[1];
      end
    end
  end

  // bus: one wait cycle per access so read data come from a flop
  assign bus_req           = avs_read_i | avs_write_i;
  assign avs_waitrequest_o = bus_req & ~ack;
  assign wr_go             = avs_write_i & ack;
  assign st_wr             = wr_go & (avs_address_i == `OFS_STATUS);

  always @* begin
    wr_val = merge16(16'h0000, avs_writedata_i, avs_byteenable_i);
    case (avs_address_i)
      `OFS_MOD_CTRL:    rd_mux = mod_ctrl;
      `OFS_X_MOD_START: rd_mux = x_start;
      `OFS_X_MOD_END:   rd_mux = x_end;
      `OFS_Y_MOD_START: rd_mux = y_start;
      `OFS_Y_MOD_END:   rd_mux = y_end;
      `OFS_STATUS:      rd_mux = {13'h0000, status};
      `OFS_BITREV_CTRL: rd_mux = bitrev_ctrl;
      default:          rd_mux = 16'h0000;
    endcase
  end

  // register file; unmapped writes are dropped, unmapped reads give zero
  always @(posedge core_clk_i) begin
    if (rst_i) begin
      ack            <= 1'b0;
      avs_readdata_o <= 32'h00000000;
      mod_ctrl       <= `MC_RESET;
      x_start        <= `START_RESET;
      x_end          <= `END_RESET;
      y_start        <= `START_RESET;
      y_end          <= `END_RESET;
      bitrev_ctrl    <= `BITREV_RESET;
    end else begin
      ack <= bus_req & ~ack;
      if (avs_read_i & ~ack) begin
        avs_readdata_o <= {16'h0000, rd_mux};
      end
      if (wr_go) begin
        case (avs_address_i)
          `OFS_MOD_CTRL:    mod_ctrl <= merge16(mod_ctrl, avs_writedata_i, avs_byteenable_i);
          // start kept even and end kept odd so a word pointer fits the buffer
          `OFS_X_MOD_START: x_start <= merge16(x_start, avs_writedata_i, avs_byteenable_i) & 16'hFFFE;
          `OFS_X_MOD_END:   x_end   <= merge16(x_end, avs_writedata_i, avs_byteenable_i) | 16'h0001;
          `OFS_Y_MOD_START: y_start <= merge16(y_start, avs_writedata_i, avs_byteenable_i) & 16'hFFFE;
          `OFS_Y_MOD_END:   y_end   <= merge16(y_end, avs_writedata_i, avs_byteenable_i) | 16'h0001;
          `OFS_BITREV_CTRL: bitrev_ctrl <= merge16(bitrev_ctrl, avs_writedata_i, avs_byteenable_i);
          default: ;
        endcase
      end
    end
  end

  // sticky status, write one to clear; a new event beats the clear
  always @(posedge core_clk_i) begin
    if (rst_i) begin
      status <= 3'h0;
    end else begin
      status[`ST_ILLEGAL] <= (status[`ST_ILLEGAL] & ~(st_wr & wr_val[`ST_ILLEGAL])) | (req_valid_i & any_bad);
      status[`ST_X_WRAP]  <= (status[`ST_X_WRAP] & ~(st_wr & wr_val[`ST_X_WRAP])) | x_wrap_evt;  // R9
      status[`ST_Y_WRAP]  <= (status[`ST_Y_WRAP] & ~(st_wr & wr_val[`ST_Y_WRAP])) | y_wrap_evt;  // R9
    end
  end

endmodule // dual_space_agu

`default_nettype wire

// [tb/dsag_checker_sva.sv]
/* dsag_checker: port-level checks on dual_space_agu.
   assumes one clock domain and the synchronous active-high reset. */
`default_nettype none
`include "dsag_defines.vh"
module dsag_checker (
  input wire logic        core_clk_i,
  input wire logic        rst_i,
  input wire logic        avs_read_i,
  input wire logic        avs_write_i,
  input wire logic        avs_waitrequest_o,
  input wire logic        req_valid_i,
  input wire logic        mac_i,
  input wire logic [3:0]  offset_register_field_i,
  input wire logic [3:0]  ofs_sel_o,
  input wire logic        a_en_i,
  input wire logic [3:0]  a_mode_i,
  input wire logic [3:0]  a_reg_i,
  input wire logic [15:0] a_ptr_i,
  input wire logic        b_en_i,
  input wire logic [3:0]  b_reg_i,
  input wire logic        valid_o,
  input wire logic        illegal_o,
  input wire logic [15:0] a_addr_o,
  input wire logic        a_space_o,
  input wire logic        a_wb_o,
  input wire logic        b_space_o,
  input wire logic        b_wb_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (rst_i);
  // a pointer outside the prefetch pairs on an enabled channel
  wire bad_ptr = (a_en_i && a_reg_i != `REG_XP1 && a_reg_i != `REG_XP2) ||
                 (b_en_i && b_reg_i != `REG_YP1 && b_reg_i != `REG_YP2);
  wire bad_mode = mac_i ? !(a_mode_i inside {`M_IND, `M_INDEX, [`M_MAC_P2:`M_MAC_N6]}) : a_mode_i >= `M_MAC_P2;

  chk_valid_latency: assert property (req_valid_i |=> valid_o)
    else $error("no valid after request");
  chk_no_spurious: assert property (!req_valid_i |=> !valid_o && !a_wb_o && !b_wb_o)
    else $error("pulse without request");
  chk_mac_ptr_set: assert property (req_valid_i && mac_i && bad_ptr |=> illegal_o && !a_wb_o && !b_wb_o)
    else $error("foreign mac pointer");
  chk_space_route: assert property (req_valid_i && mac_i && b_en_i |=> !a_space_o && (b_space_o || illegal_o))
    else $error("wrong space");
  chk_mac_index: assert property (req_valid_i && mac_i && a_en_i && a_mode_i == `M_INDEX &&
                                  a_reg_i != `REG_XP2 |=> illegal_o)
    else $error("mac index on wrong pointer");
  chk_mode_class: assert property (req_valid_i && a_en_i && bad_mode |=> illegal_o)
    else $error("bad mode accepted");
  chk_ind_addr: assert property (req_valid_i && a_en_i && a_mode_i == `M_IND |=>
                                 illegal_o || (a_addr_o == $past(a_ptr_i) && !a_wb_o))
    else $error("indirect address wrong");
  chk_postmod_wb: assert property (req_valid_i && mac_i && a_en_i && a_reg_i == `REG_XP1 &&
                                   a_mode_i == `M_MAC_P2 |=> illegal_o || a_wb_o)
    else $error("no post-modify write back");
  chk_offset_share: assert property (ofs_sel_o == offset_register_field_i)
    else $error("offset select differs");
  chk_wait_once: assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o |=> !avs_waitrequest_o)
    else $error("more than one wait cycle");
  chk_wb_legal: assert property (a_wb_o || b_wb_o |-> valid_o && !illegal_o)
    else $error("write back when refused");

  cover property (valid_o && a_wb_o && b_wb_o);
  cover property (valid_o && illegal_o);
  cover property (avs_read_i && !avs_waitrequest_o);
endmodule // dsag_checker
`default_nettype wire

// [tb/reg_file_model.sv]
/* reg_file_model: working register file seen by the address generator.
   assumes write back pulses arrive one cycle after each request. */
`default_nettype none
module reg_file_model (
  input wire logic        core_clk_i,
  input wire logic [3:0]  a_reg_i,
  input wire logic [3:0]  b_reg_i,
  input wire logic [3:0]  ofs_sel_i,
  input wire logic        a_wb_i,
  input wire logic        b_wb_i,
  input wire logic [15:0] a_wb_data_i,
  input wire logic [15:0] b_wb_data_i,
  output logic     [15:0] a_ptr_o,
  output logic     [15:0] b_ptr_o,
  output logic     [15:0] ofs_data_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] regs [16];
  // contents read combinationally, one offset register for both operands
  assign a_ptr_o = regs[a_reg_i];
  assign b_ptr_o = regs[b_reg_i];
  assign ofs_data_o = regs[ofs_sel_i];
  // updated pointers land at the edge after the result
  always @(posedge core_clk_i) begin
    if (a_wb_i) regs[a_reg_i] <= a_wb_data_i;
    if (b_wb_i) regs[b_reg_i] <= b_wb_data_i;
  end
  // software preload; callers keep x pointers in x space, y in y space
  task automatic load(input logic [3:0] r, input logic [15:0] v);
    regs[r] = v;
  endtask
endmodule // reg_file_model
`default_nettype wire

// [tb/testbench.sv]
/* testbench: self-checking bench for dual_space_agu.
   assumes a 100 MHz core clock and registers over Avalon-MM. */
`default_nettype none
`include "dsag_defines.vh"
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic        core_clk_i = 1'b0, rst_i = 1'b1, avs_read_i = 1'b0, avs_write_i = 1'b0;
  logic [7:0]  avs_address_i = 8'h00;
  logic [31:0] avs_writedata_i = 32'h0, avs_readdata_o;
  logic        avs_waitrequest_o, req_valid_i = 1'b0, mac_i = 1'b0, byte_i = 1'b0, a_en_i = 1'b1, b_en_i = 1'b0;
  logic [3:0]  offset_register_field_i = 4'h5, a_mode_i = 4'h0, a_reg_i = 4'h0, b_mode_i = 4'h0, b_reg_i = 4'h0;
  logic [15:0] lit_i = 16'h12AB, ofs_data_i, a_ptr_i, b_ptr_i, a_addr_o, b_addr_o, a_wb_data_o, b_wb_data_o;
  logic [3:0]  ofs_sel_o;
  logic [1:0]  a_kind_o, b_kind_o;
  logic        valid_o, illegal_o, a_space_o, b_space_o, a_wb_o, b_wb_o;
  int          failures = 0, checked = 0, cycles = 0;

  dual_space_agu dual_space_agu_i (.core_clk_i, .rst_i, .avs_address_i, .avs_read_i, .avs_write_i,
    .avs_writedata_i, .avs_byteenable_i(4'h3), .avs_readdata_o, .avs_waitrequest_o, .req_valid_i, .mac_i,
    .byte_i, .offset_register_field_i, .ofs_data_i, .lit_i, .a_en_i, .a_mode_i, .a_reg_i, .a_ptr_i, .b_en_i,
    .b_mode_i, .b_reg_i, .b_ptr_i, .ofs_sel_o, .valid_o, .illegal_o, .a_addr_o, .a_kind_o, .a_space_o,
    .a_wb_o, .a_wb_data_o, .b_addr_o, .b_kind_o, .b_space_o, .b_wb_o, .b_wb_data_o);
  reg_file_model reg_file_model_i (.core_clk_i, .a_reg_i, .b_reg_i, .ofs_sel_i(ofs_sel_o), .a_wb_i(a_wb_o),
    .b_wb_i(b_wb_o), .a_wb_data_i(a_wb_data_o), .b_wb_data_i(b_wb_data_o), .a_ptr_o(a_ptr_i),
    .b_ptr_o(b_ptr_i), .ofs_data_o(ofs_data_i));

  initial forever #5 core_clk_i = ~core_clk_i;
  // hang guard: the run needs under a thousand cycles
  always @(posedge core_clk_i) begin
    cycles++;
    if (cycles == 5000) begin
      failures++;
      stop_test();
    end
  end

  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    checked++;
    if (s !== e) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", nm, e, s);
    end
  endtask

  // one Avalon transfer; waitrequest sampled at each rising edge
  task automatic bus(input logic w, input logic [7:0] ad, input logic [15:0] wd, output logic [31:0] rd);
    @(posedge core_clk_i);
    avs_address_i <= ad;
    avs_writedata_i <= {16'h0000, wd};
    avs_write_i <= w;
    avs_read_i <= ~w;
    do @(posedge core_clk_i); while (avs_waitrequest_o !== 1'b0);
    rd = avs_readdata_o;
    avs_write_i <= 1'b0;
    avs_read_i <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] ad, input logic [15:0] d);
    logic [31:0] x;
    bus(1'b1, ad, d, x);
  endtask

  task automatic rdc(input logic [7:0] ad, input logic [31:0] e);
    logic [31:0] x;
    bus(1'b0, ad, 16'h0000, x);
    chk("readdata", x, e);
  endtask

  // one decoder request; results are judged in the cycle valid stands
  task automatic issue(input logic m, input logic [3:0] am, ar, input logic be, input logic [3:0] bm, br);
    @(posedge core_clk_i);
    req_valid_i <= 1'b1;
    mac_i <= m;
    a_mode_i <= am;
    a_reg_i <= ar;
    b_en_i <= be;
    b_mode_i <= bm;
    b_reg_i <= br;
    @(posedge core_clk_i);
    req_valid_i <= 1'b0;
    #1;
  endtask

  task automatic t_regs();
    logic [7:0]  ad [8] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h50, 8'h20};
    logic [15:0] rv [8] = '{16'h0, 16'h0, 16'h1, 16'h0, 16'h1, 16'h0, 16'h0, 16'h0};
    for (int i = 0; i < 8; i++) rdc(ad[i], {16'h0, rv[i]});
    wr(`OFS_BITREV_CTRL, 16'h8005);
    rdc(`OFS_BITREV_CTRL, 32'h00008005);
    wr(`OFS_BITREV_CTRL, 16'h0);
    wr(`OFS_X_MOD_START, 16'h0101);
    rdc(`OFS_X_MOD_START, 32'h00000100);
    wr(8'h20, 16'hFFFF);
    rdc(8'h20, 32'h00000000);
    $display("test registers done");
  endtask

  task automatic t_mac();
    logic [15:0] xp = 16'h0100, yp = 16'h0800;
    logic [3:0]  im [4] = '{`M_MAC_P2, `M_INDEX, `M_POSTINC, `M_MAC_P2};
    logic [3:0]  ir [4] = '{4'hC, `REG_XP1, `REG_XP1, 4'h3};
    reg_file_model_i.load(`REG_XP1, xp);
    reg_file_model_i.load(`REG_YP1, yp);
    for (int i = 0; i < 3; i++) begin
      issue(1'b1, `M_MAC_P2 + 4'(i), `REG_XP1, 1'b1, `M_MAC_N2 + 4'(i), `REG_YP1);
      chk("mac_flags", {valid_o, illegal_o, a_space_o, b_space_o, a_wb_o, b_wb_o}, 6'b100111);
      chk("mac_addr", {a_addr_o, b_addr_o}, {xp, yp});
      xp = xp + 16'(2 * i + 2);
      yp = yp - 16'(2 * i + 2);
      chk("mac_wb", {a_wb_data_o, b_wb_data_o}, {xp, yp});
    end
    for (int k = 0; k < 4; k++) begin
      issue(k != 3, im[k], ir[k], 1'b0, 4'h0, 4'h0);
      chk("refused", {valid_o, illegal_o, a_wb_o, b_wb_o}, 4'b1100);
    end
    reg_file_model_i.load(`REG_XP2, 16'h0200);
    reg_file_model_i.load(`REG_YP2, 16'h0900);
    reg_file_model_i.load(4'h5, 16'h0010);
    issue(1'b1, `M_INDEX, `REG_XP2, 1'b1, `M_INDEX, `REG_YP2);
    chk("mac_index", {illegal_o, a_wb_o, b_wb_o, b_space_o}, 4'b0001);
    chk("index_addr", {a_addr_o, b_addr_o}, 32'h02100910);
    $display("test mac done");
  endtask

  task automatic t_move();
    logic [15:0] ea [10] = '{16'h0000, 16'h0300, 16'h0300, 16'h0300, 16'h0302, 16'h02FE, 16'h0310, 16'h15AB,
                             16'h00AB, 16'h12AB};
    logic [15:0] wd [10] = '{16'h0, 16'h0, 16'h0302, 16'h02FE, 16'h0302, 16'h02FE, 16'h0, 16'h0, 16'h0, 16'h0};
    logic [1:0]  kd [10] = '{2'h1, 2'h0, 2'h0, 2'h0, 2'h0, 2'h0, 2'h0, 2'h0, 2'h2, 2'h2};
    for (int m = 0; m < 10; m++) begin
      repeat (2) @(negedge core_clk_i);
      reg_file_model_i.load(4'h3, 16'h0300);
      reg_file_model_i.load(4'h4, 16'h0300);
      issue(1'b0, 4'(m), 4'h3, 1'b1, 4'(9 - m), 4'h4);
      chk("move_flags", {valid_o, illegal_o, a_wb_o, b_wb_o}, {2'b10, m inside {[2:5]}, (9 - m) inside {[2:5]}});
      chk("move_kind", {a_kind_o, b_kind_o}, {kd[m], kd[9 - m]});
      if (m != 0) chk("src_addr", a_addr_o, ea[m]);
      if (m != 9) chk("dst_addr", b_addr_o, ea[9 - m]);
      if (a_wb_o === 1'b1) chk("src_wb", a_wb_data_o, wd[m]);
      if (b_wb_o === 1'b1) chk("dst_wb", b_wb_data_o, wd[9 - m]);
    end
    chk("ofs_sel", ofs_sel_o, 4'h5);
    $display("test move done");
  endtask

  task automatic t_modulo();
    wr(`OFS_STATUS, 16'h0007);
    wr(`OFS_X_MOD_START, 16'h0100);
    wr(`OFS_X_MOD_END, 16'h0107);
    wr(`OFS_Y_MOD_START, 16'h0800);
    wr(`OFS_Y_MOD_END, 16'h080F);
    wr(`OFS_MOD_CTRL, 16'h2A83);
    reg_file_model_i.load(`REG_XP1, 16'h0106);
    reg_file_model_i.load(`REG_YP1, 16'h0800);
    issue(1'b1, `M_MAC_P2, `REG_XP1, 1'b1, `M_MAC_N2, `REG_YP1);
    chk("wrap", {a_wb_data_o, b_wb_data_o}, 32'h0100080E);
    rdc(`OFS_STATUS, 32'h00000006);
    wr(`OFS_STATUS, 16'h0006);
    rdc(`OFS_STATUS, 32'h00000000);
    wr(`OFS_MOD_CTRL, 16'h6A83);
    reg_file_model_i.load(`REG_XP1, 16'h0100);
    issue(1'b1, `M_MAC_N2, `REG_XP1, 1'b0, 4'h0, 4'h0);
    chk("bidir_wrap", a_wb_data_o, 16'h0106);
    wr(`OFS_MOD_CTRL, 16'h6AE3);
    reg_file_model_i.load(4'hE, 16'h0106);
    issue(1'b0, `M_POSTINC, 4'hE, 1'b0, 4'h0, 4'h0);
    chk("frame_wrap", {a_wb_o, a_wb_data_o}, 17'h10100);
    $display("test modulo done");
  endtask

  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  initial begin
    repeat (4) @(posedge core_clk_i);
    rst_i <= 1'b0;
    t_regs();
    t_mac();
    t_move();
    t_modulo();
    stop_test();
  end
endmodule // testbench

bind dual_space_agu dsag_checker dsag_checker_i (.core_clk_i, .rst_i, .avs_read_i, .avs_write_i,
  .avs_waitrequest_o, .req_valid_i, .mac_i, .offset_register_field_i, .ofs_sel_o, .a_en_i, .a_mode_i,
  .a_reg_i, .a_ptr_i, .b_en_i, .b_reg_i, .valid_o, .illegal_o, .a_addr_o, .a_space_o, .a_wb_o, .b_space_o,
  .b_wb_o);
`default_nettype wire
